// ---- hdl/daq_conversion_sequencer.sv ----
// Acquisition and conversion sequencer with channel addressing and three-state result
`timescale 1ns/1ps
// Summary of operation
// - Trigger falling edge starts acquisition then conversion
// - Source select low loads address, high sequences
// - Address-zero request forces channel 0, overriding source
// - Channel-switch enable low disconnects every channel
// - Random address taken from four weighted inputs
// - Status high during conversion, low when done
// - Bits 1-4 driven only while group enable low
// - Bits 5-8 driven only while group enable low
// - Bits 9-12 driven while their enable low
// - Self-start begins one conversion after reset
// - Acquisition lasts at most 10 us untrimmed
// - Bits 9-12 released while their enable high
// - Current channel address shown on four outputs
// - Conversion within 10 us; result valid when status falls
module daq_conversion_sequencer #(
    parameter int RESULT_BITS = daq_pkg::RESULT_BITS,
    parameter int ACQ_BASE_CYCLES = daq_pkg::ACQ_BASE_CYCLES,
    parameter int ACQ_TRIM_CYCLES = daq_pkg::ACQ_TRIM_CYCLES
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic strobe_n,
    input wire logic load_n,
    input wire logic clear_n,
    input wire logic mux_enable,
    input wire logic [3:0] channel_select_in,
    input wire logic [2:0] group_enable_n,
    input wire logic [3:0] acquisition_delay_trim,
    input wire logic [11:0] analog_level,
    output logic conversion_busy,
    output logic [3:0] channel_select_out,
    output logic [15:0] mux_channel_on,
    output daq_pkg::result_bus_t result_pins
);
    daq_pkg::seq_state_t state;
    daq_pkg::seq_state_t next_state;
    logic strobe_prev;
    logic self_start;
    logic seq_step;
    logic [11:0] acq_count;
    logic [11:0] held_level;
    logic conv_start;
    logic next_self_start;
    logic next_seq_step;
    logic [11:0] next_acq_count;
    logic [11:0] next_held_level;
    logic next_conv_start;
    logic next_busy;
    logic [3:0] next_addr;
    logic [11:0] next_level;
    logic [11:0] next_drive;
    logic [15:0] next_mux;
    logic [11:0] acq_target;
    logic trigger;
    logic conv_done;
    logic [11:0] conv_result;

    sar_converter #(
        .BITS(RESULT_BITS)
    ) u_sar (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .start(conv_start),
        .held_level(held_level),
        .done(conv_done),
        .result(conv_result)
    );

    // Trim lengthens the one-shot for high-gain settling; zero gives the untrimmed time
    assign acq_target = 12'(ACQ_BASE_CYCLES)
        + 12'(acquisition_delay_trim) * 12'(ACQ_TRIM_CYCLES);
    // The pending self-start acts as one synthetic trigger
    assign trigger = (strobe_prev & ~strobe_n) | self_start;

    always_comb begin
        next_state = state;
        next_self_start = self_start;
        next_seq_step = seq_step;
        next_acq_count = acq_count;
        next_held_level = held_level;
        next_conv_start = 1'b0;
        next_addr = channel_select_out;
        next_level = result_pins.level;
        case (state)
            daq_pkg::ST_IDLE: begin
                // Triggers during acquisition or conversion are ignored
                if (trigger) begin
                    next_state = daq_pkg::ST_ACQUIRE;
                    next_self_start = 1'b0;
                    next_acq_count = 12'h000;
                    next_seq_step = clear_n & load_n;
                    if (!clear_n) begin
                        next_addr = daq_pkg::ADDR_RESET;
                    end else if (!load_n) begin
                        next_addr = channel_select_in;
                    end
                end
            end
            daq_pkg::ST_ACQUIRE: begin
                if (acq_count >= acq_target - 12'h001) begin
                    next_state = daq_pkg::ST_CONVERT;
                    next_held_level = analog_level;
                    next_conv_start = 1'b1;
                end else begin
                    next_acq_count = acq_count + 12'h001;
                end
            end
            daq_pkg::ST_CONVERT: begin
                if (conv_done) begin
                    next_state = daq_pkg::ST_IDLE;
                    next_level = conv_result;
                    if (seq_step) begin
                        next_addr = channel_select_out + 4'h1;
                    end
                end
            end
            default: begin
                next_state = daq_pkg::ST_IDLE;
            end
        endcase
        next_busy = (next_state == daq_pkg::ST_CONVERT);
    end

    // Mux switches and result output enables follow their control inputs
    always_comb begin
        next_mux = daq_pkg::MUX_OFF;
        if (mux_enable) begin
            next_mux[channel_select_out] = 1'b1;
        end
    end

    genvar g;
    generate
        for (g = 0; g < daq_pkg::GROUPS; g++) begin : gen_group
            // Group 2 holds bits 1-4 (MSB end), group 0 holds bits 9-12
            assign next_drive[g*4 +: 4] = {4{~group_enable_n[g]}};
        end
    endgenerate

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= daq_pkg::ST_IDLE;
            strobe_prev <= 1'b1;
            self_start <= 1'b1;
            seq_step <= 1'b0;
            acq_count <= 12'h000;
            held_level <= daq_pkg::RESULT_RESET;
            conv_start <= 1'b0;
            conversion_busy <= 1'b0;
            channel_select_out <= daq_pkg::ADDR_RESET;
            mux_channel_on <= daq_pkg::MUX_OFF;
            result_pins <= '0;
        end else begin
            state <= next_state;
            strobe_prev <= strobe_n;
            self_start <= next_self_start;
            seq_step <= next_seq_step;
            acq_count <= next_acq_count;
            held_level <= next_held_level;
            conv_start <= next_conv_start;
            conversion_busy <= next_busy;
            channel_select_out <= next_addr;
            mux_channel_on <= next_mux;
            result_pins.level <= next_level;
            result_pins.drive <= next_drive;
        end
    end

    // Checks
    property p_trigger_starts;
        @(posedge core_clk) disable iff (!reset_n)
        state == daq_pkg::ST_IDLE && strobe_prev && !strobe_n |=> state == daq_pkg::ST_ACQUIRE;
    endproperty
    a_trigger_starts: assert property (p_trigger_starts) else $error("trigger ignored");

    property p_random_load;
        @(posedge core_clk) disable iff (!reset_n)
        state == daq_pkg::ST_IDLE && trigger && clear_n && !load_n
        |=> channel_select_out == $past(channel_select_in);
    endproperty
    a_random_load: assert property (p_random_load) else $error("random address lost");

    property p_seq_hold;
        @(posedge core_clk) disable iff (!reset_n)
        state == daq_pkg::ST_IDLE && trigger && clear_n && load_n |=> $stable(channel_select_out);
    endproperty
    a_seq_hold: assert property (p_seq_hold) else $error("sequential address moved");

    property p_clear_zero;
        @(posedge core_clk) disable iff (!reset_n)
        state == daq_pkg::ST_IDLE && trigger && !clear_n |=> channel_select_out == 4'h0;
    endproperty
    a_clear_zero: assert property (p_clear_zero) else $error("address not cleared");

    property p_mux_gate;
        @(posedge core_clk) disable iff (!reset_n)
        1'b1 |=> mux_channel_on == ($past(mux_enable) ? (16'h0001 << $past(channel_select_out))
            : 16'h0000);
    endproperty
    a_mux_gate: assert property (p_mux_gate) else $error("mux switch wrong");

    property p_busy_after_acq;
        @(posedge core_clk) disable iff (!reset_n)
        $rose(conversion_busy) |-> $past(state) == daq_pkg::ST_ACQUIRE;
    endproperty
    a_busy_after_acq: assert property (p_busy_after_acq) else $error("busy without acquire");

    property p_acq_bound;
        @(posedge core_clk) disable iff (!reset_n)
        state == daq_pkg::ST_ACQUIRE && acquisition_delay_trim == 4'h0
        |-> acq_count < 12'(daq_pkg::ACQ_MAX_CYCLES);
    endproperty
    a_acq_bound: assert property (p_acq_bound) else $error("acquisition too long");

    property p_conv_bound;
        @(posedge core_clk) disable iff (!reset_n)
        $rose(conversion_busy) |-> ##[1:1000] !conversion_busy;
    endproperty
    a_conv_bound: assert property (p_conv_bound) else $error("conversion too long");

    property p_result_valid;
        @(posedge core_clk) disable iff (!reset_n)
        $fell(conversion_busy) |-> result_pins.level == conv_result;
    endproperty
    a_result_valid: assert property (p_result_valid) else $error("result not valid");

    property p_seq_step;
        @(posedge core_clk) disable iff (!reset_n)
        state == daq_pkg::ST_CONVERT && conv_done && seq_step
        |=> channel_select_out == 4'($past(channel_select_out) + 4'h1);
    endproperty
    a_seq_step: assert property (p_seq_step) else $error("address did not step");

    property p_group_hi;
        @(posedge core_clk) disable iff (!reset_n)
        1'b1 |=> result_pins.drive[11:8] == {4{!$past(group_enable_n[2])}};
    endproperty
    a_group_hi: assert property (p_group_hi) else $error("bits 1-4 drive wrong");

    property p_group_mid;
        @(posedge core_clk) disable iff (!reset_n)
        group_enable_n[1] |=> result_pins.drive[7:4] == 4'h0;
    endproperty
    a_group_mid: assert property (p_group_mid) else $error("bits 5-8 not released");

    property p_group_lo;
        @(posedge core_clk) disable iff (!reset_n)
        group_enable_n[0] ##1 !group_enable_n[0] |=> result_pins.drive[3:0] == 4'hF;
    endproperty
    a_group_lo: assert property (p_group_lo) else $error("bits 9-12 drive wrong");

    property p_self_start;
        @(posedge core_clk) disable iff (!reset_n)
        self_start && state == daq_pkg::ST_IDLE |=> state == daq_pkg::ST_ACQUIRE;
    endproperty
    a_self_start: assert property (p_self_start) else $error("no self start");

    c_random: cover property (@(posedge core_clk) disable iff (!reset_n)
        state == daq_pkg::ST_IDLE && trigger && clear_n && !load_n);
    c_wrap: cover property (@(posedge core_clk) disable iff (!reset_n)
        channel_select_out == 4'hF ##1 channel_select_out == 4'h0);
    c_clear: cover property (@(posedge core_clk) disable iff (!reset_n)
        state == daq_pkg::ST_IDLE && trigger && !clear_n);
    c_done: cover property (@(posedge core_clk) disable iff (!reset_n) $fell(conversion_busy));
endmodule

// ---- hdl/daq_pkg.sv ----
// Shared constants, state codes and carrier types of the conversion sequencer
package daq_pkg;
    localparam int CLK_PERIOD_NS = 10;

    // Widths of the converter and multiplexer
    localparam int RESULT_BITS = 12;
    localparam int ADDR_BITS = 4;
    localparam int CHANNELS = 16;
    localparam int GROUPS = 3;
    localparam int GROUP_BITS = 4;
    localparam int TRIM_BITS = 4;
    localparam int COUNT_BITS = 12;

    // Acquisition one-shot: nominal 9 us and never beyond 10 us with the trim input at zero
    localparam int ACQ_BASE_NS = 9000;
    localparam int ACQ_BASE_CYCLES = (ACQ_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACQ_MAX_NS = 10000;
    localparam int ACQ_MAX_CYCLES = ACQ_MAX_NS / CLK_PERIOD_NS;
    localparam int ACQ_TRIM_STEP_NS = 1000;
    localparam int ACQ_TRIM_CYCLES = (ACQ_TRIM_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Gated conversion clock: one bit decision per step
    localparam int SAR_BIT_NS = 600;
    localparam int SAR_BIT_CYCLES = (SAR_BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CONV_MAX_NS = 10000;
    localparam int CONV_MAX_CYCLES = CONV_MAX_NS / CLK_PERIOD_NS;

    // Reset values
    localparam logic [3:0] ADDR_RESET = 4'h0;
    localparam logic [11:0] RESULT_RESET = 12'h000;
    localparam logic [15:0] MUX_OFF = 16'h0000;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ACQUIRE = 2'b01,
        ST_CONVERT = 2'b10
    } seq_state_t;

    // Three-state result pins: level[11] is bit 1 (MSB), level[0] is bit 12 (LSB)
    typedef struct packed {
        logic [11:0] level;
        logic [11:0] drive;
    } result_bus_t;
endpackage

// ---- hdl/sar_converter.sv ----
// Successive-approximation converter stepped by a gated internal clock
`timescale 1ns/1ps
module sar_converter #(
    parameter int BITS = 12
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic start,
    input wire logic [BITS-1:0] held_level,
    output logic done,
    output logic [BITS-1:0] result
);
    logic busy;
    logic [3:0] bit_index;
    logic [6:0] tick;
    logic next_busy;
    logic next_done;
    logic [3:0] next_bit_index;
    logic [6:0] next_tick;
    logic [BITS-1:0] next_result;
    logic [BITS-1:0] trial;

    always_comb begin
        next_busy = busy;
        next_done = 1'b0;
        next_bit_index = bit_index;
        next_tick = tick;
        next_result = result;
        trial = result | (BITS'(1) << bit_index);
        if (start) begin
            next_busy = 1'b1;
            next_bit_index = 4'(BITS - 1);
            next_tick = 7'h00;
            next_result = '0;
        end else if (busy) begin
            if (tick == 7'(daq_pkg::SAR_BIT_CYCLES - 1)) begin
                next_tick = 7'h00;
                // Keep the trial bit only if the held level is not below it
                if (trial <= held_level) begin
                    next_result = trial;
                end
                if (bit_index == 4'h0) begin
                    next_busy = 1'b0;
                    next_done = 1'b1;
                end else begin
                    next_bit_index = bit_index - 4'h1;
                end
            end else begin
                next_tick = tick + 7'h01;
            end
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            busy <= 1'b0;
            done <= 1'b0;
            bit_index <= 4'h0;
            tick <= 7'h00;
            result <= '0;
        end else begin
            busy <= next_busy;
            done <= next_done;
            bit_index <= next_bit_index;
            tick <= next_tick;
            result <= next_result;
        end
    end
endmodule

// ---- test/host_model.sv ----
// Host controller that strobes conversions on request
`timescale 1ns/1ps
module host_model #(
    parameter int PULSE_CYCLES = 3,
    parameter int START_WAIT = 400
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic fire,
    input wire logic conversion_busy,
    output logic strobe_n
);
    int low_left = 0;
    int idle_count = 0;
    logic started = 1'b0;

    initial begin
        strobe_n = 1'b1;
    end

    // The pulse stays far shorter than the busy period, so no conversion slot is lost
    always @(negedge core_clk) begin
        if (!reset_n) begin
            strobe_n <= 1'b1;
            low_left <= 0;
            idle_count <= 0;
            started <= 1'b0;
        end else begin
            if (conversion_busy) begin
                started <= 1'b1;
            end else if (!started) begin
                idle_count <= idle_count + 1;
            end
            if (fire || (!started && idle_count == START_WAIT)) begin
                strobe_n <= 1'b0;
                low_left <= PULSE_CYCLES - 1;
            end else if (low_left > 0) begin
                low_left <= low_left - 1;
            end else begin
                strobe_n <= 1'b1;
            end
        end
    end
endmodule

// ---- test/tb_daq_conversion_sequencer.sv ----
// Self-checking testbench of the conversion sequencer
`timescale 1ns/1ps
module tb_daq_conversion_sequencer;
    localparam int BASE = 20;
    localparam int TRIM_STEP = 5;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic strobe_n;
    logic fire = 1'b0;
    logic load_n = 1'b1;
    logic clear_n = 1'b0;
    logic mux_enable = 1'b1;
    logic [3:0] channel_select_in = 4'h0;
    logic [2:0] group_enable_n = 3'h0;
    logic [3:0] acquisition_delay_trim = 4'h0;
    logic [11:0] analog_level = 12'hA5C;
    logic conversion_busy;
    logic [3:0] channel_select_out;
    logic [15:0] mux_channel_on;
    daq_pkg::result_bus_t pins;
    wire [11:0] data_bus;
    int fail_count = 0;
    int n_tests = 0;
    int seed = 32'hCBE5F710;
    int n;
    logic [3:0] exp_addr = 4'h0;
    // Reference model: levels sampled for each conversion, in launch order
    logic [11:0] exp_q[$];

    daq_conversion_sequencer #(.ACQ_BASE_CYCLES(BASE), .ACQ_TRIM_CYCLES(TRIM_STEP)) i_dut (
        .core_clk(core_clk), .reset_n(reset_n), .strobe_n(strobe_n), .load_n(load_n),
        .clear_n(clear_n), .mux_enable(mux_enable), .channel_select_in(channel_select_in),
        .group_enable_n(group_enable_n), .acquisition_delay_trim(acquisition_delay_trim),
        .analog_level(analog_level), .conversion_busy(conversion_busy),
        .channel_select_out(channel_select_out), .mux_channel_on(mux_channel_on),
        .result_pins(pins));

    host_model i_host (.core_clk(core_clk), .reset_n(reset_n), .fire(fire),
        .conversion_busy(conversion_busy), .strobe_n(strobe_n));

    // Three-state pins resolved here, as the board would see them
    for (genvar g = 0; g < 12; g++) begin : g_pin
        assign data_bus[g] = pins.drive[g] ? pins.level[g] : 1'bz;
    end

    initial begin
        forever #5 core_clk = ~core_clk;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic wait_level(input logic lvl, output int cnt);
        cnt = 0;
        while (conversion_busy !== lvl && cnt < 3000) begin
            @(posedge core_clk);
            #1;
            cnt++;
        end
    endtask

    // mode 0 random load, 1 sequential, 2 clear to channel 0
    task automatic convert(input int mode, input bit refuse, input logic [3:0] sel);
        int cnt;
        int t;
        logic [3:0] trim;
        logic [11:0] lvl;
        logic [11:0] exp_bus;
        @(negedge core_clk);
        lvl = 12'($random(seed));
        trim = 4'($random(seed) & 3);
        t = BASE + TRIM_STEP * trim;
        analog_level <= lvl;
        exp_q.push_back(lvl);
        channel_select_in <= sel;
        acquisition_delay_trim <= trim;
        load_n <= (mode != 0);
        clear_n <= (mode != 2);
        mux_enable <= 1'($random(seed));
        group_enable_n <= 3'($random(seed));
        fire <= 1'b1;
        @(negedge core_clk);
        fire <= 1'b0;
        if (mode != 1) exp_addr = (mode == 0) ? sel : 4'h0;
        if (refuse) begin
            fork
                begin
                    repeat (6) @(negedge core_clk);
                    fire <= 1'b1;
                    @(negedge core_clk);
                    fire <= 1'b0;
                end
            join_none
        end
        @(posedge core_clk);
        @(posedge core_clk);
        #1;
        check("address", channel_select_out, exp_addr);
        cnt = 1;
        while (conversion_busy !== 1'b1 && cnt < 3000) begin
            @(posedge core_clk);
            #1;
            cnt++;
        end
        // Busy rises exactly t edges after the edge that takes the trigger
        check("acq_cycles", cnt, t);
        wait_level(1'b0, cnt);
        check("conv_bound", cnt <= daq_pkg::CONV_MAX_CYCLES, 1'b1);
        check("result", pins.level, exp_q.pop_front());
        if (mode == 1) exp_addr++;
        repeat (2) @(posedge core_clk);
        #1;
        check("step", channel_select_out, exp_addr);
        check("mux", mux_channel_on, mux_enable ? 16'h1 << exp_addr : 16'h0);
        for (int b = 0; b < 12; b++) exp_bus[b] = group_enable_n[b / 4] ? 1'bz : lvl[b];
        check("data_bus", data_bus, exp_bus);
        if (refuse) begin
            // A strobe edge during acquisition must leave no second conversion behind
            repeat (60) @(posedge core_clk);
            #1;
            check("refused", conversion_busy, 1'b0);
        end
    endtask

    initial begin
        repeat (3) @(negedge core_clk);
        reset_n <= 1'b1;
        exp_q.push_back(analog_level);
        wait_level(1'b1, n);
        check("self_start", conversion_busy, 1'b1);
        wait_level(1'b0, n);
        check("self_result", pins.level, exp_q.pop_front());
        for (int i = 0; i < 15; i++) begin
            convert(i % 3, i == 7, (i == 3) ? 4'hF : 4'($random(seed)));
        end
        end_of_test();
    end

    // About 15 conversions of under 900 cycles each; allow generous margin
    initial begin
        #400000;
        fail_count++;
        end_of_test();
    end
endmodule
